// *** testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ttc_pkg::*;
    typedef struct {logic [31:0] data; logic [31:0] mask; logic [1:0] resp;} ttc_exp_s;
    localparam logic [15:0] PRE [3] = '{16'hff1f, 16'hffff, 16'h80ff};
    localparam logic [15:0] EXP [3] = '{16'h0000, 16'h0000, 16'h8080};
    localparam logic [15:0] MSK [3] = '{16'hff1f, 16'hffff, 16'hffff};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, clk_out, clk_oe_n;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    ttc_pins_s pins;
    ttc_status_s status;
    int miscompares = 0;
    int comparisons = 0;
    ttc_exp_s exq[$];
    ttc_exp_s head;
    always #20 aclk = ~aclk;

    ttc_timer_unit dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins(pins),
        .clockout_pin_out(clk_out), .clockout_pin_oe_n(clk_oe_n), .status(status));
    ttc_pin_model pm_u (.aclk(aclk), .co_out(clk_out), .co_oe_n(clk_oe_n), .pins(pins));

    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic results();
        if (miscompares == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic hang(input int n);
        if (n > 100) begin
            miscompares++;
            results();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            hang(n);
        end while (!(bvalid && bready));
        bready <= 1'b0;
        chk("bresp", 32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        exq.push_back('{e, m, er});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            hang(n);
        end while (!(rvalid && rready));
        rready <= 1'b0;
    endtask
    // cycles between two changes of the clock output
    task automatic half_per(output int n);
        logic v;
        repeat (2) begin
            v = clk_out;
            n = 0;
            while (clk_out === v && n < 200) begin
                @(posedge aclk);
                n++;
            end
        end
    endtask
    // bounded wait for a one-cycle overflow pulse
    task automatic catch_pulse(input bit third, output logic v);
        int k;
        k = 0;
        v = 1'b0;
        while (!v && k < 100) begin
            @(posedge aclk);
            k++;
            v = third ? status.third_ovf_pulse : status.second_ovf_pulse;
        end
    endtask
    // read answers against the oldest note
    always @(posedge aclk) begin
        if (rvalid && rready && exq.size() > 0) begin
            head = exq.pop_front();
            chk("rdata", rdata & head.mask, head.data);
            chk("rresp", 32'(rresp), 32'(head.resp));
        end
    end

    initial begin
        int i;
        int n;
        int base;
        logic v;
        void'($urandom(29));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 9; i++)
            rd(8'(i * 4), 32'h0, 32'hffffffff, RESP_OKAY);
        rd(8'h24, 32'h0, 32'hffffffff, RESP_SLVERR);
        wr(8'h24, 32'hff, RESP_SLVERR);
        base = $urandom_range(0, 200);
        n = $urandom_range(1, 4);
        wr(OFF_CNT0, 32'(base), RESP_OKAY);
        wr(OFF_GMODE, 32'h0d, RESP_OKAY);
        pm_u.gate0_n <= 1'b0;
        wr(OFF_GCTRL, 32'h10, RESP_OKAY);
        pm_u.pulse(0, 2, 24);
        rd(OFF_CNT0, 32'(base), 32'hffff, RESP_OKAY);
        pm_u.gate0_n <= 1'b1;
        pm_u.pulse(0, n, 24);
        rd(OFF_CNT0, 32'(base + n), 32'hffff, RESP_OKAY);
        for (i = 0; i < 3; i++) begin
            wr(OFF_GMODE, 32'(4 | i), RESP_OKAY);
            wr(OFF_CNT0, 32'(PRE[i]), RESP_OKAY);
            wr(OFF_GCTRL, 32'h10, RESP_OKAY);
            pm_u.pulse(0, 1, 24);
            chk("tf0", 32'(status.first_timer_overflow), 32'h1);
            rd(OFF_CNT0, 32'(EXP[i]), 32'(MSK[i]), RESP_OKAY);
        end
        wr(OFF_GMODE, 32'h33, RESP_OKAY);
        wr(OFF_CNT1, 32'h1234, RESP_OKAY);
        wr(OFF_CNT0, 32'hff00, RESP_OKAY);
        wr(OFF_GCTRL, 32'h40, RESP_OKAY);
        repeat (400) @(posedge aclk);
        rd(OFF_CNT1, 32'h1234, 32'hffff, RESP_OKAY);
        rd(OFF_GCTRL, 32'hc0, 32'hff, RESP_OKAY);
        chk("tf1", 32'(status.second_timer_overflow), 32'h1);
        wstrb <= 4'h2;
        wr(OFF_CNT1, 32'hffff, RESP_OKAY);
        wstrb <= 4'hf;
        rd(OFF_CNT1, 32'hff34, 32'hffff, RESP_OKAY);
        wr(OFF_GMODE, 32'h23, RESP_OKAY);
        wr(OFF_CNT1, 32'hfefe, RESP_OKAY);
        wr(OFF_GCTRL, 32'h40, RESP_OKAY);
        catch_pulse(1'b0, v);
        chk("t1 pulse", 32'(v), 32'h1);
        chk("tf1 clear", 32'(status.second_timer_overflow), 32'h0);
        wr(OFF_CNT2, 32'h1234, RESP_OKAY);
        wr(OFF_T2CTRL, 32'h0f, RESP_OKAY);
        pm_u.pulse(2, 1, 24);
        chk("t2 event", 32'(status.third_timer_event), 32'h1);
        rd(OFF_CAP2, 32'h1234, 32'hffff, RESP_OKAY);
        pm_u.pulse(1, 1, 24);
        rd(OFF_CNT2, 32'h1235, 32'hffff, RESP_OKAY);
        rd(OFF_T2CTRL, 32'h4f, 32'hff, RESP_OKAY);
        wr(OFF_CAP2, 32'hfff0, RESP_OKAY);
        wr(OFF_CNT2, 32'hfff0, RESP_OKAY);
        wr(OFF_T2MODE, 32'h2, RESP_OKAY);
        wr(OFF_T2CTRL, 32'h04, RESP_OKAY);
        repeat (100) @(posedge aclk);
        chk("oe_n", 32'(clk_oe_n), 32'h0);
        half_per(n);
        chk("half period", 32'(n), 32'd32);
        wr(OFF_CLKCFG, 32'h1, RESP_OKAY);
        half_per(n);
        chk("half period six", 32'(n), 32'd16);
        rd(OFF_T2CTRL, 32'h04, 32'hff, RESP_OKAY);
        wr(OFF_T2CTRL, 32'h14, RESP_OKAY);
        catch_pulse(1'b1, v);
        chk("t2 pulse", 32'(v), 32'h1);
        repeat (200) @(posedge aclk);
        rd(OFF_T2CTRL, 32'h14, 32'hff, RESP_OKAY);
        results();
    end
endmodule

// *** ttc_pin_model.sv ***
module ttc_pin_model (
    // clock
    input wire logic aclk,
    // design side of the shared pin
    input wire logic co_out,
    input wire logic co_oe_n,
    // pins toward the design
    output ttc_pkg::ttc_pins_s pins
);
    import ttc_pkg::*;
    logic gate0_n = 1'b1;
    logic cnt0 = 1'b1;
    logic cap = 1'b1;
    logic ext = 1'b1;
    // shared pin follows whoever drives it
    assign pins = {gate0_n, 1'b1, cnt0, 1'b1, cap, co_oe_n ? ext : co_out};
    // falling edges, each level held gap clocks
    task automatic pulse(input int which, input int n, input int gap);
        repeat (n) begin
            repeat (gap) @(posedge aclk);
            cnt0 <= (which != 0);
            ext <= (which != 1);
            cap <= (which != 2);
            repeat (gap) @(posedge aclk);
            cnt0 <= 1'b1;
            ext <= 1'b1;
            cap <= 1'b1;
        end
    endtask
endmodule

// *** ttc_pkg.sv ***
package ttc_pkg;
    // --------------------------------------------------------------
    // register map
    // --------------------------------------------------------------
    localparam logic [7:0] OFF_GCTRL = 8'h00;
    localparam logic [7:0] OFF_GMODE = 8'h04;
    localparam logic [7:0] OFF_CNT0 = 8'h08;
    localparam logic [7:0] OFF_CNT1 = 8'h0c;
    localparam logic [7:0] OFF_T2CTRL = 8'h10;
    localparam logic [7:0] OFF_T2MODE = 8'h14;
    localparam logic [7:0] OFF_CNT2 = 8'h18;
    localparam logic [7:0] OFF_CAP2 = 8'h1c;
    localparam logic [7:0] OFF_CLKCFG = 8'h20;
    // general control fields
    localparam int GC_TF1 = 7;
    localparam int GC_TR1 = 6;
    localparam int GC_TF0 = 5;
    localparam int GC_TR0 = 4;
    // general mode fields
    localparam int GM_GATE1 = 7;
    localparam int GM_CT1 = 6;
    localparam int GM_GATE0 = 3;
    localparam int GM_CT0 = 2;
    // third timer control, third timer mode and clock config fields
    localparam int T2_TF = 7;
    localparam int T2_EXF = 6;
    localparam int T2_RCLK = 5;
    localparam int T2_TRANSMIT_CLOCK_SELECT = 4;
    localparam int T2_EXEN = 3;
    localparam int T2_TR = 2;
    localparam int T2_CT = 1;
    localparam int T2_CPRL = 0;
    localparam int T2M_CLKOE = 1;
    localparam int CFG_SIX = 0;
    // reset values, timing and bus response codes
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [3:0] MC_LAST_12 = 4'hb;
    localparam logic [3:0] MC_LAST_6 = 4'h5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // --------------------------------------------------------------
    // types
    // --------------------------------------------------------------
    typedef enum logic [1:0] {MODE_13BIT, MODE_16BIT, MODE_RELOAD8, MODE_SPLIT} ttc_mode_e;
    typedef enum logic [1:0] {T2_OFF, T2_BAUD, T2_CAPTURE, T2_RELOAD} ttc_t2mode_e;

    typedef struct packed {
        logic first_gate_pin_n;
        logic second_gate_pin_n;
        logic first_count_pin;
        logic second_count_pin;
        logic capture_reload_pin;
        logic count_or_clockout_pin;
    } ttc_pins_s;

    typedef struct packed {
        logic first_timer_overflow;
        logic second_timer_overflow;
        logic third_timer_event;
        logic second_ovf_pulse;
        logic third_ovf_pulse;
    } ttc_status_s;

    // one count step: {overflow, next count}
    function automatic logic [16:0] ttc_step(input ttc_mode_e m, input logic [15:0] c);
        logic [12:0] v13;
        logic [7:0] lo;
        v13 = {c[15:8], c[4:0]} + 13'h0001;
        lo = c[7:0] + 8'h01;
        unique case (m)
            MODE_13BIT: ttc_step = {&{c[15:8], c[4:0]}, v13[12:5], c[7:5], v13[4:0]};
            MODE_16BIT: ttc_step = {&c, 16'(c + 16'h0001)};
            MODE_RELOAD8: ttc_step = {&c[7:0], c[15:8], (&c[7:0]) ? c[15:8] : lo};
            MODE_SPLIT: ttc_step = {&c[7:0], c[15:8], lo};
        endcase
    endfunction
endpackage

// *** ttc_timer_unit.sv ***
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
module ttc_timer_unit #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire ttc_pkg::ttc_pins_s pins,
    output logic clockout_pin_out,
    output logic clockout_pin_oe_n,
    // flags and overflow pulses
    output ttc_pkg::ttc_status_s status
);
    import ttc_pkg::*;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        hit = ({a[ADDR_W-1:2], 2'b00} == ADDR_W'(off));
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    logic run0_reg, run1_reg, tf0_reg, tf1_reg;
    logic [7:0] gmode_reg;
    logic [15:0] cnt0_reg, cnt1_reg, cnt2_reg, cap2_reg;
    logic [15:0] cnt0_next, cnt1_next, cnt2_next, cap2_next;
    logic tf2_reg, external_event_flag_reg, clkoe_reg, six_reg;
    logic [5:0] t2cfg_reg;
    logic clkout_reg, pulse1_reg, pulse2_reg;
    ttc_pins_s sync1_reg, sync2_reg, samp_reg, fall;
    logic [3:0] mc_cnt_reg;
    logic half_reg, mcycle_en, fast_en;

    // --------------------------------------------------------------
    // axi4-lite slave
    // --------------------------------------------------------------
    logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg, rdata_reg;
    logic [3:0] w_strb_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic wr_do, wr_map, lo_en;
    logic we_gctrl, we_gmode, we_cnt0, we_cnt1, we_t2c, we_t2m, we_cnt2, we_cap2, we_cfg;
    logic [15:0] rd_val;
    logic rd_map;

    assign s_axi_awready = !aw_hold_reg;
    assign s_axi_wready = !w_hold_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    assign wr_do = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign lo_en = wr_do && w_strb_reg[0];
    assign we_gctrl = lo_en && hit(aw_addr_reg, OFF_GCTRL);
    assign we_gmode = lo_en && hit(aw_addr_reg, OFF_GMODE);
    assign we_t2c = lo_en && hit(aw_addr_reg, OFF_T2CTRL);
    assign we_t2m = lo_en && hit(aw_addr_reg, OFF_T2MODE);
    assign we_cfg = lo_en && hit(aw_addr_reg, OFF_CLKCFG);
    assign we_cnt0 = wr_do && hit(aw_addr_reg, OFF_CNT0);
    assign we_cnt1 = wr_do && hit(aw_addr_reg, OFF_CNT1);
    assign we_cnt2 = wr_do && hit(aw_addr_reg, OFF_CNT2);
    assign we_cap2 = wr_do && hit(aw_addr_reg, OFF_CAP2);
    assign wr_map = hit(aw_addr_reg, OFF_GCTRL) || hit(aw_addr_reg, OFF_GMODE) || hit(aw_addr_reg, OFF_CNT0)
        || hit(aw_addr_reg, OFF_CNT1) || hit(aw_addr_reg, OFF_T2CTRL) || hit(aw_addr_reg, OFF_T2MODE)
        || hit(aw_addr_reg, OFF_CNT2) || hit(aw_addr_reg, OFF_CAP2) || hit(aw_addr_reg, OFF_CLKCFG);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
        end else begin
            if (s_axi_awvalid && !aw_hold_reg) begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold_reg) begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        rd_map = 1'b1;
        rd_val = RST_WORD;
        if (hit(s_axi_araddr, OFF_GCTRL)) rd_val = {8'h00, tf1_reg, run1_reg, tf0_reg, run0_reg, 4'h0};
        else if (hit(s_axi_araddr, OFF_GMODE)) rd_val = {8'h00, gmode_reg};
        else if (hit(s_axi_araddr, OFF_CNT0)) rd_val = cnt0_reg;
        else if (hit(s_axi_araddr, OFF_CNT1)) rd_val = cnt1_reg;
        else if (hit(s_axi_araddr, OFF_T2CTRL)) rd_val = {8'h00, tf2_reg, external_event_flag_reg, t2cfg_reg};
        else if (hit(s_axi_araddr, OFF_T2MODE)) rd_val = {14'h0000, clkoe_reg, 1'b0};
        else if (hit(s_axi_araddr, OFF_CNT2)) rd_val = cnt2_reg;
        else if (hit(s_axi_araddr, OFF_CAP2)) rd_val = cap2_reg;
        else if (hit(s_axi_araddr, OFF_CLKCFG)) rd_val = {15'h0000, six_reg};
        else rd_map = 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {16'h0000, rd_val};
            rresp_reg <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // machine cycle divider and pin sampling
    // --------------------------------------------------------------
    assign mcycle_en = mc_cnt_reg >= (six_reg ? MC_LAST_6 : MC_LAST_12);
    assign fast_en = six_reg || half_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn || mcycle_en) mc_cnt_reg <= 4'h0;
        else mc_cnt_reg <= mc_cnt_reg + 4'h1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) half_reg <= 1'b0;
        else half_reg <= !half_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            samp_reg <= '0;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            if (mcycle_en) samp_reg <= sync2_reg;
        end
    end

    // high-to-low seen between two machine-cycle samples
    assign fall = ttc_pins_s'(samp_reg & ~sync2_reg & {$bits(ttc_pins_s){mcycle_en}});

    // --------------------------------------------------------------
    // timers 0 and 1
    // --------------------------------------------------------------
    ttc_mode_e mode0, mode1;
    logic split0, src0, src1, inc0, inc0h, inc1, ovf0, ovf0h, ovf1;
    logic [16:0] st0, st1;

    assign mode0 = ttc_mode_e'(gmode_reg[1:0]);
    assign mode1 = ttc_mode_e'(gmode_reg[5:4]);
    assign split0 = (mode0 == MODE_SPLIT);
    assign src0 = gmode_reg[GM_CT0] ? fall.first_count_pin : mcycle_en;
    assign src1 = gmode_reg[GM_CT1] ? fall.second_count_pin : mcycle_en;
    assign inc0 = run0_reg && (!gmode_reg[GM_GATE0] || sync2_reg.first_gate_pin_n) && src0;
    assign inc1 = run1_reg && (!gmode_reg[GM_GATE1] || sync2_reg.second_gate_pin_n) && src1
        && (mode1 != MODE_SPLIT);
    // split high byte: machine cycles on timer 1 run bit
    assign inc0h = split0 && run1_reg && mcycle_en;
    assign st0 = ttc_step(mode0, cnt0_reg);
    assign st1 = ttc_step(mode1, cnt1_reg);
    assign ovf0 = inc0 && st0[16];
    assign ovf0h = inc0h && (&cnt0_reg[15:8]);
    assign ovf1 = inc1 && st1[16];

    always_comb begin
        cnt0_next = inc0 ? st0[15:0] : cnt0_reg;
        if (inc0h) cnt0_next[15:8] = cnt0_next[15:8] + 8'h01;
        if (we_cnt0) cnt0_next = merge16(cnt0_next, w_data_reg, w_strb_reg);
        cnt1_next = inc1 ? st1[15:0] : cnt1_reg;
        if (we_cnt1) cnt1_next = merge16(cnt1_next, w_data_reg, w_strb_reg);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt0_reg <= RST_WORD;
            cnt1_reg <= RST_WORD;
        end else begin
            cnt0_reg <= cnt0_next;
            cnt1_reg <= cnt1_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run0_reg <= 1'b0;
            run1_reg <= 1'b0;
            tf0_reg <= 1'b0;
            tf1_reg <= 1'b0;
            gmode_reg <= RST_BYTE;
        end else begin
            // run bits only gate counting, counts untouched
            if (we_gctrl) run0_reg <= w_data_reg[GC_TR0];
            if (we_gctrl) run1_reg <= w_data_reg[GC_TR1];
            if (we_gmode) gmode_reg <= w_data_reg[7:0];
            tf0_reg <= (we_gctrl ? w_data_reg[GC_TF0] : tf0_reg) || ovf0;
            tf1_reg <= (we_gctrl ? w_data_reg[GC_TF1] : tf1_reg) || (split0 ? ovf0h : ovf1);
        end
    end

    // --------------------------------------------------------------
    // timer 2
    // --------------------------------------------------------------
    ttc_t2mode_e mode2;
    logic clkout, fast2, src2, inc2, ovf2, edge2, reload2;

    always_comb begin
        if (!t2cfg_reg[T2_TR]) mode2 = T2_OFF;
        else if (t2cfg_reg[T2_RCLK] || t2cfg_reg[T2_TRANSMIT_CLOCK_SELECT]) mode2 = T2_BAUD;
        else if (t2cfg_reg[T2_CPRL]) mode2 = T2_CAPTURE;
        else mode2 = T2_RELOAD;
    end

    // pin driven as clock output when enabled in timer mode
    assign clkout = clkoe_reg && !t2cfg_reg[T2_CT];
    assign fast2 = (mode2 == T2_BAUD) || clkout;
    assign src2 = t2cfg_reg[T2_CT] ? fall.count_or_clockout_pin : (fast2 ? fast_en : mcycle_en);
    assign inc2 = (mode2 != T2_OFF) && src2;
    assign ovf2 = inc2 && (&cnt2_reg);
    assign edge2 = t2cfg_reg[T2_EXEN] && fall.capture_reload_pin;
    // capture mode never reloads unless clock output needs it
    assign reload2 = (ovf2 && ((mode2 != T2_CAPTURE) || clkout)) || (edge2 && mode2 == T2_RELOAD);

    always_comb begin
        cnt2_next = reload2 ? cap2_reg : (inc2 ? 16'(cnt2_reg + 16'h0001) : cnt2_reg);
        if (we_cnt2) cnt2_next = merge16(cnt2_next, w_data_reg, w_strb_reg);
        cap2_next = we_cap2 ? merge16(cap2_reg, w_data_reg, w_strb_reg) : cap2_reg;
        if (edge2 && mode2 == T2_CAPTURE && !clkout) cap2_next = cnt2_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt2_reg <= RST_WORD;
            cap2_reg <= RST_WORD;
        end else begin
            cnt2_reg <= cnt2_next;
            cap2_reg <= cap2_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tf2_reg <= 1'b0;
            external_event_flag_reg <= 1'b0;
            t2cfg_reg <= 6'h00;
            clkoe_reg <= 1'b0;
            six_reg <= 1'b0;
        end else begin
            if (we_t2c) t2cfg_reg <= w_data_reg[5:0];
            if (we_t2m) clkoe_reg <= w_data_reg[T2M_CLKOE];
            if (we_cfg) six_reg <= w_data_reg[CFG_SIX];
            tf2_reg <= (we_t2c ? w_data_reg[T2_TF] : tf2_reg)
                || (ovf2 && mode2 != T2_BAUD && !clkout);
            external_event_flag_reg <= (we_t2c ? w_data_reg[T2_EXF] : external_event_flag_reg) || (edge2 && mode2 != T2_OFF);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !clkout) clkout_reg <= 1'b0;
        else if (ovf2) clkout_reg <= !clkout_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pulse1_reg <= 1'b0;
            pulse2_reg <= 1'b0;
        end else begin
            pulse1_reg <= ovf1;
            pulse2_reg <= ovf2;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign clockout_pin_out = clkout_reg;
    assign clockout_pin_oe_n = !clkout;
    assign status = ttc_status_s'({tf0_reg, tf1_reg, tf2_reg || external_event_flag_reg, pulse1_reg, pulse2_reg});

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    property p_t0_hold;
        @(posedge aclk) disable iff (!aresetn)
        (!run0_reg && !we_cnt0 && !split0) |=> cnt0_reg == $past(cnt0_reg);
    endproperty
    a_t0_hold: assert property (p_t0_hold) else $error("timer 0 moved while stopped");

    property p_t0_wrap;
        @(posedge aclk) disable iff (!aresetn)
        (inc0 && mode0 == MODE_16BIT && cnt0_reg == 16'hffff && !we_cnt0 && !we_gctrl)
            |=> tf0_reg && cnt0_reg == 16'h0000;
    endproperty
    a_t0_wrap: assert property (p_t0_wrap) else $error("16-bit wrap missed flag");

    property p_t0_reload;
        @(posedge aclk) disable iff (!aresetn)
        (inc0 && mode0 == MODE_RELOAD8 && cnt0_reg[7:0] == 8'hff && !we_cnt0)
            |=> cnt0_reg[7:0] == $past(cnt0_reg[15:8]) && cnt0_reg[15:8] == $past(cnt0_reg[15:8]);
    endproperty
    a_t0_reload: assert property (p_t0_reload) else $error("8-bit reload wrong");

    property p_t0_13bit;
        @(posedge aclk) disable iff (!aresetn)
        (inc0 && mode0 == MODE_13BIT && cnt0_reg[4:0] == 5'h1f && !we_cnt0)
            |=> cnt0_reg[15:8] == 8'($past(cnt0_reg[15:8]) + 8'h01) && cnt0_reg[4:0] == 5'h00;
    endproperty
    a_t0_13bit: assert property (p_t0_13bit) else $error("13-bit carry wrong");

    property p_t1_hold;
        @(posedge aclk) disable iff (!aresetn)
        (mode1 == MODE_SPLIT && !we_cnt1) |=> cnt1_reg == $past(cnt1_reg);
    endproperty
    a_t1_hold: assert property (p_t1_hold) else $error("timer 1 counted in mode 3");

    property p_split_high;
        @(posedge aclk) disable iff (!aresetn)
        (split0 && run1_reg && mcycle_en && cnt0_reg[15:8] == 8'hff) |=> tf1_reg;
    endproperty
    a_split_high: assert property (p_split_high) else $error("split high byte flag missed");

    property p_capture;
        @(posedge aclk) disable iff (!aresetn)
        (mode2 == T2_CAPTURE && edge2 && !clkout) |=> cap2_reg == $past(cnt2_reg) && external_event_flag_reg;
    endproperty
    a_capture: assert property (p_capture) else $error("capture not taken");

    property p_cap_count;
        @(posedge aclk) disable iff (!aresetn)
        (mode2 == T2_CAPTURE && !clkout && inc2 && !we_cnt2) |=> cnt2_reg == 16'($past(cnt2_reg) + 16'h0001);
    endproperty
    a_cap_count: assert property (p_cap_count) else $error("capture mode count wrong");

    property p_baud_noflag;
        @(posedge aclk) disable iff (!aresetn)
        ((t2cfg_reg[T2_RCLK] || t2cfg_reg[T2_TRANSMIT_CLOCK_SELECT]) && !tf2_reg && !we_t2c) |=> !tf2_reg;
    endproperty
    a_baud_noflag: assert property (p_baud_noflag) else $error("overflow flag set in baud mode");

    property p_mcycle;
        @(posedge aclk) disable iff (!aresetn)
        (mcycle_en && !six_reg && !we_cfg) |=> !mcycle_en [*8];
    endproperty
    a_mcycle: assert property (p_mcycle) else $error("machine cycle too short");

    property p_clkout;
        @(posedge aclk) disable iff (!aresetn)
        (clkout && ovf2 && !we_t2m && !we_t2c) |=> clkout_reg != $past(clkout_reg);
    endproperty
    a_clkout: assert property (p_clkout) else $error("clock output did not toggle");
endmodule
